// file: inc/serial_shifter_defines.svh
`ifndef SERIAL_SHIFTER_DEFINES_SVH
`define SERIAL_SHIFTER_DEFINES_SVH

// Overview of operation
// - Shifter runs only while control bit 2 set.
// - Interrupt request only when control bit 1 set.
// - Writing control bit 3 with bit 2, while idle, clears counter, starts.
// - Completion sets pending bit 0, requests interrupt if mask bit 0 set.
// - Control register resets to 00H, internal clock.
// - Reset selects receive-only, clears bit counter.
// - Direction bit picks MSB or LSB first.
// - Internal rate is fxx/4 over prescaler plus one.
// - Edge bit 0: output changes on falling edges.
// - Edge bit 1: output changes on rising edges.
// - Source bit picks driven or received shift clock.
// - Every completed transfer moves exactly eight bits.
// - Control register sits at address F3H.
// - Prescaler register sits at address F5H.

// ****************************************************************
// Register map
// ****************************************************************
`define SIO_ADDR_W         8
`define SIO_DATA_W         8
`define SIO_CTRL_ADDR      8'hf3
`define SIO_BUF_ADDR       8'hf4
`define SIO_BAUD_ADDR      8'hf5
`define SIO_STAT_ADDR      8'hf6
`define SIO_MASK_ADDR      8'hf7

// ****************************************************************
// Control register fields
// ****************************************************************
`define SIO_CTRL_PEND      0
`define SIO_CTRL_IE        1
`define SIO_CTRL_EN        2
`define SIO_CTRL_START     3
`define SIO_CTRL_EDGE      4
`define SIO_CTRL_LSB       5
`define SIO_CTRL_TXRX      6
`define SIO_CTRL_EXT       7

// ****************************************************************
// Status and mask fields
// ****************************************************************
`define SIO_EVT_W          2
`define SIO_EVT_DONE       0
`define SIO_EVT_OVR        1

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define SIO_CTRL_RESET     8'h00
`define SIO_BAUD_RESET     8'h00
`define SIO_BUF_RESET      8'h00
`define SIO_EVT_RESET      2'h0
`define SIO_CNT_W          3
`define SIO_CNT_LAST       3'h7
`define SIO_PREDIV_LAST    1'h1

`endif

// file: inc/serial_shifter_pkg.sv
`include "serial_shifter_defines.svh"

package serial_shifter_pkg;

	typedef logic [`SIO_DATA_W-1:0] byte_t;
	typedef logic [`SIO_ADDR_W-1:0] addr_t;
	typedef logic [`SIO_EVT_W-1:0]  evt_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_SHIFT = 2'b10
	} shift_state_t;

	typedef struct packed {
		shift_state_t            state;
		byte_t                   ctrl;
		byte_t                   baud;
		byte_t                   sreg;
		logic [`SIO_CNT_W-1:0]   cnt;
		logic                    last;
		logic                    smp;
		logic                    sck;
		logic                    sck_oe;
		logic                    sdo;
		logic                    sck_s1;
		logic                    sck_s2;
		logic                    sck_s3;
		logic                    sdi_s1;
		logic                    sdi_s2;
		evt_t                    status;
		evt_t                    mask;
		byte_t                   rdata;
		logic                    irq;
	} shifter_state_t;

	typedef struct packed {
		logic                    pre;
		byte_t                   cnt;
		logic                    tick;
	} divider_state_t;

endpackage

// file: src/shift_clock_divider.sv
module shift_clock_divider #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_sys_in,
	input  wire logic             rst_n_in,
	input  wire logic             run_in,
	input  wire logic [WIDTH-1:0] divisor_in,
	output logic                  tick_out
);
	import serial_shifter_pkg::*;

	divider_state_t s_q;
	divider_state_t s_d;

	// ****************************************************************
	// Half-period ticks: fxx/2 then divided by divisor plus one.
	// ****************************************************************
	always_comb begin
		s_d      = s_q;
		s_d.tick = 1'b0;
		if (!run_in) begin
			s_d.pre = 1'b0;
			s_d.cnt = '0;
		end else begin
			s_d.pre = ~s_q.pre;
			if (s_q.pre == `SIO_PREDIV_LAST) begin
				if (s_q.cnt == divisor_in) begin
					s_d.cnt  = '0;
					s_d.tick = 1'b1;
				end else begin
					s_d.cnt = 8'(s_q.cnt + 8'h01);
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick_out = s_q.tick;

endmodule

// file: src/synchronous_serial_shifter.sv
// Chosen here: the strobed register port.
module synchronous_serial_shifter (
	input  wire logic                    clk_sys_in,
	input  wire logic                    rst_n_in,
	input  wire serial_shifter_pkg::addr_t addr_in,
	input  wire serial_shifter_pkg::byte_t wdata_in,
	input  wire logic                    wr_in,
	input  wire logic                    rd_in,
	output serial_shifter_pkg::byte_t    rdata_out,
	output logic                         irq_out,
	input  wire logic                    sck_in,
	output logic                         sck_out,
	output logic                         sck_oe_out,
	input  wire logic                    sdi_in,
	output logic                         sdo_out
);
	import serial_shifter_pkg::*;

	shifter_state_t s_q;
	shifter_state_t s_d;
	logic           tick;

	// ****************************************************************
	// Bit selection for the serial output and shift-in of the serial input.
	// ****************************************************************
	function automatic logic out_bit(input byte_t sreg, input logic lsb_first);
		out_bit = lsb_first ? sreg[0] : sreg[7];
	endfunction

	function automatic byte_t shift_in(input byte_t sreg, input logic lsb_first, input logic din);
		shift_in = lsb_first ? {din, sreg[7:1]} : {sreg[6:0], din};
	endfunction

	// ****************************************************************
	// Internal shift clock rate.
	// ****************************************************************
	shift_clock_divider #(
		.WIDTH      (`SIO_DATA_W)
	) u_divider (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.run_in     (s_q.state == ST_SHIFT && !s_q.ctrl[`SIO_CTRL_EXT]),
		.divisor_in (s_q.baud),
		.tick_out   (tick)
	);

	// ****************************************************************
	// Next state.
	// ****************************************************************
	always_comb begin
		logic ext;
		logic edge_sel;
		logic lsb;
		logic txrx;
		logic rise;
		logic fall;
		logic smp_edge;
		logic tx_edge;
		logic ev_done;
		logic ev_ovr;
		ext      = s_q.ctrl[`SIO_CTRL_EXT];
		edge_sel = s_q.ctrl[`SIO_CTRL_EDGE];
		lsb      = s_q.ctrl[`SIO_CTRL_LSB];
		txrx     = s_q.ctrl[`SIO_CTRL_TXRX];
		rise     = 1'b0;
		fall     = 1'b0;
		smp_edge = 1'b0;
		tx_edge  = 1'b0;
		ev_done  = 1'b0;
		ev_ovr   = 1'b0;
		s_d      = s_q;

		// Pins from the far side pass two flops before use.
		s_d.sck_s1 = sck_in;
		s_d.sck_s2 = s_q.sck_s1;
		s_d.sck_s3 = s_q.sck_s2;
		s_d.sdi_s1 = sdi_in;
		s_d.sdi_s2 = s_q.sdi_s1;
		s_d.rdata  = '0;
		s_d.smp    = 1'b0;
		s_d.sck_oe = ~ext;

		// Edge detection on the driven or the received clock.
		if (ext) begin
			rise = s_q.sck_s2 & ~s_q.sck_s3;
			fall = ~s_q.sck_s2 & s_q.sck_s3;
		end else if (tick) begin
			rise = ~s_q.sck;
			fall = s_q.sck;
		end
		smp_edge = edge_sel ? fall : rise;
		tx_edge  = edge_sel ? rise : fall;

		unique case (s_q.state)
			ST_IDLE: begin
				if (!ext) begin
					s_d.sck = edge_sel;
				end
			end
			ST_SHIFT: begin
				if (!s_q.ctrl[`SIO_CTRL_EN]) begin
					s_d.state = ST_IDLE;
					s_d.last  = 1'b0;
				end else begin
					if (!ext && tick) begin
						s_d.sck = ~s_q.sck;
					end
					// The own clock samples one cycle late, so that data changed on the last transmit edge has
					// crossed the input synchroniser even at the fastest rate.
					s_d.smp = smp_edge & ~ext;
					if (ext ? smp_edge : s_q.smp) begin
						s_d.sreg = shift_in(s_q.sreg, lsb, s_q.sdi_s2);
						s_d.cnt  = 3'(s_q.cnt + 3'h1);
						if (s_q.cnt == `SIO_CNT_LAST) begin
							if (ext) begin
								ev_done   = 1'b1;
								s_d.state = ST_IDLE;
							end else begin
								s_d.last = 1'b1;
							end
						end
					end
					if (tx_edge) begin
						if (s_q.last) begin
							ev_done   = 1'b1;
							s_d.last  = 1'b0;
							s_d.state = ST_IDLE;
						end else if (txrx) begin
							s_d.sdo = out_bit(s_q.sreg, lsb);
						end
					end
				end
			end
		endcase

		// Register writes.
		if (wr_in) begin
			unique case (addr_in)
				`SIO_CTRL_ADDR: begin
					s_d.ctrl = wdata_in;
					s_d.ctrl[`SIO_CTRL_START] = 1'b0;
					// Clearing the enable stops a transfer at once, without a pending flag.
					if (!wdata_in[`SIO_CTRL_EN]) begin
						s_d.state = ST_IDLE;
						s_d.last  = 1'b0;
						s_d.smp   = 1'b0;
					end
					// An idle own clock takes its new resting level with the write itself.
					if ((s_q.state == ST_IDLE || !wdata_in[`SIO_CTRL_EN]) && !wdata_in[`SIO_CTRL_EXT]) begin
						s_d.sck = wdata_in[`SIO_CTRL_EDGE];
					end
					if (wdata_in[`SIO_CTRL_START] && wdata_in[`SIO_CTRL_EN]) begin
						if (s_q.state == ST_IDLE) begin
							s_d.state = ST_SHIFT;
							s_d.cnt   = '0;
							s_d.last  = 1'b0;
							if (!wdata_in[`SIO_CTRL_EXT]) begin
								s_d.sck = wdata_in[`SIO_CTRL_EDGE];
							end
							if (wdata_in[`SIO_CTRL_TXRX]) begin
								s_d.sdo = out_bit(s_q.sreg, wdata_in[`SIO_CTRL_LSB]);
							end
						end else begin
							ev_ovr = 1'b1;
						end
					end
				end
				`SIO_BUF_ADDR: begin
					if (s_q.state == ST_IDLE) begin
						s_d.sreg = wdata_in;
					end else begin
						ev_ovr = 1'b1;
					end
				end
				`SIO_BAUD_ADDR: begin
					s_d.baud = wdata_in;
				end
				`SIO_MASK_ADDR: begin
					s_d.mask = wdata_in[`SIO_EVT_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Register reads; status clears when read.
		if (rd_in) begin
			unique case (addr_in)
				`SIO_CTRL_ADDR: begin
					s_d.rdata = s_q.ctrl;
				end
				`SIO_BUF_ADDR: begin
					s_d.rdata = s_q.sreg;
				end
				`SIO_BAUD_ADDR: begin
					s_d.rdata = s_q.baud;
				end
				`SIO_STAT_ADDR: begin
					s_d.rdata  = {6'h00, s_q.status};
					s_d.status = '0;
				end
				`SIO_MASK_ADDR: begin
					s_d.rdata = {6'h00, s_q.mask};
				end
				default: begin
				end
			endcase
		end

		// Hardware sets win over clears in the same cycle.
		if (ev_done) begin
			s_d.ctrl[`SIO_CTRL_PEND]  = 1'b1;
			s_d.status[`SIO_EVT_DONE] = 1'b1;
		end
		if (ev_ovr) begin
			s_d.status[`SIO_EVT_OVR] = 1'b1;
		end

		s_d.irq = s_d.ctrl[`SIO_CTRL_IE] & |(s_d.status & s_d.mask);
	end

	// ****************************************************************
	// State register.
	// ****************************************************************
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			s_q        <= '0;
			s_q.state  <= ST_IDLE;
			s_q.ctrl   <= `SIO_CTRL_RESET;
			s_q.baud   <= `SIO_BAUD_RESET;
			s_q.sreg   <= `SIO_BUF_RESET;
			s_q.status <= `SIO_EVT_RESET;
			s_q.mask   <= `SIO_EVT_RESET;
			s_q.sck_oe <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************************************
	// Outputs.
	// ****************************************************************
	assign rdata_out  = s_q.rdata;
	assign irq_out    = s_q.irq;
	assign sck_out    = s_q.sck;
	assign sck_oe_out = s_q.sck_oe;
	assign sdo_out    = s_q.sdo;

endmodule

// file: test/serial_peer_model.sv
module serial_peer_model (
	input  wire logic clk_sys_in,
	input  wire logic sck_in,
	input  wire logic sdo_in,
	output logic      sck_out,
	output logic      sdi_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] tx       = 8'h00;
	logic [7:0] rx       = 8'h00;
	logic       edge_sel = 1'b0;
	logic       lsb      = 1'b0;
	int         n        = 9;

	initial begin
		sck_out = 1'b0;
		sdi_out = 1'b0;
	end

	task automatic load(input logic [7:0] p, input logic e, input logic l);
		tx       = p;
		edge_sel = e;
		lsb      = l;
		n        = 0;
		sdi_out  <= l ? p[0] : p[7];
	endtask

	// Eight full clocks, ending at the idle level.
	task automatic ext_run();
		repeat (16) begin
			repeat (6) @(posedge clk_sys_in);
			sck_out <= ~sck_out;
		end
	endtask

	// Released data line shows the inverse of its last bit.
	always @(sck_in) begin
		if (n < 8 && sck_in != edge_sel) begin
			rx = lsb ? {sdo_in, rx[7:1]} : {rx[6:0], sdo_in};
			n++;
		end else if (n < 8) begin
			sdi_out = lsb ? tx[n] : tx[7 - n];
		end else if (n == 8) begin
			sdi_out = ~sdi_out;
			n = 9;
		end
	end
endmodule

// file: test/serial_shifter_checker.sv
`include "serial_shifter_defines.svh"

module serial_shifter_checker (
	input wire logic       clk_sys_in,
	input wire logic       rst_n_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       wr_in,
	input wire logic       rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic       irq_out,
	input wire logic       sck_out,
	input wire logic       sck_oe_out,
	input wire logic       sdo_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import serial_shifter_pkg::*;

	byte_t      ctl_q;
	byte_t      baud_q;
	logic [1:0] st_q;
	logic [9:0] gap_q;
	logic [9:0] half;
	logic       ctrl_wr;

	assign ctrl_wr = wr_in && addr_in == `SIO_CTRL_ADDR;
	assign half    = {1'b0, baud_q, 1'b0} + 10'h002;

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	// ********
	// Shadow of the control settings and shift clock spacing
	// ********
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			ctl_q  <= 8'h00;
			baud_q <= 8'h00;
			st_q   <= 2'h0;
			gap_q  <= 10'h000;
		end else begin
			if (ctrl_wr)
				ctl_q <= wdata_in;
			if (wr_in && addr_in == `SIO_BAUD_ADDR)
				baud_q <= wdata_in;
			st_q  <= {st_q[0], ctrl_wr && wdata_in[3]};
			gap_q <= $changed(sck_out) ? 10'h000 : gap_q + {9'h000, ~&gap_q};
		end
	end

	// ********
	// Properties
	// ********
	sequence s_ctrl_set;
		ctrl_wr ##1 !ctrl_wr;
	endsequence

	property p_reset;
		disable iff (1'b0) !rst_n_in |=> rdata_out == 8'h00 && !irq_out && sck_oe_out && !sdo_out && !sck_out;
	endproperty
	a_reset: assert property (p_reset) else $error("output not at reset value");

	property p_unmapped;
		rd_in && (addr_in < 8'hf3 || addr_in > 8'hf7) |=> rdata_out == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	property p_sck_oe;
		s_ctrl_set |=> sck_oe_out == !$past(wdata_in[7], 2);
	endproperty
	a_sck_oe: assert property (p_sck_oe) else $error("clock pin drive wrong");

	property p_irq_ie;
		irq_out |-> ctl_q[1] || $past(ctl_q[1]);
	endproperty
	a_irq_ie: assert property (p_irq_ie) else $error("interrupt without enable");

	property p_half;
		$changed(sck_out) && sck_oe_out && sck_out == ctl_q[4] && gap_q < 2 * half && !$past(ctrl_wr)
			|-> gap_q == half - 10'h001;
	endproperty
	a_half: assert property (p_half) else $error("shift clock half period wrong");

	property p_tx_edge;
		$changed(sdo_out) && sck_oe_out |-> ($changed(sck_out) && sck_out == ctl_q[4]) || st_q != 2'h0;
	endproperty
	a_tx_edge: assert property (p_tx_edge) else $error("data out moved off its edge");

	property p_rx_only;
		!ctl_q[6] && !$past(ctl_q[6]) |-> $stable(sdo_out);
	endproperty
	a_rx_only: assert property (p_rx_only) else $error("data out moved in receive mode");

	property p_disabled;
		!ctl_q[2] && !$past(ctl_q[2]) && !$past(ctrl_wr) |-> $stable(sck_out) && $stable(sdo_out);
	endproperty
	a_disabled: assert property (p_disabled) else $error("shifter active while disabled");
endmodule

bind synchronous_serial_shifter serial_shifter_checker chk_u (.clk_sys_in, .rst_n_in, .addr_in, .wdata_in,
	.wr_in, .rd_in, .rdata_out, .irq_out, .sck_out, .sck_oe_out, .sdo_out);

// file: test/testbench.sv
`include "serial_shifter_defines.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("BAD %0t got %h", $time, a); end end

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import serial_shifter_pkg::*;

	logic  clk_sys_in = 1'b0;
	logic  rst_n_in   = 1'b0;
	addr_t addr_in    = 8'h00;
	byte_t wdata_in   = 8'h00;
	logic  wr_in      = 1'b0;
	logic  rd_in      = 1'b0;
	byte_t rdata_out;
	byte_t v;
	logic  irq_out, sck_out, sck_oe_out, sdo_out, sdi_in, peer_sck;
	wire   sck_in     = sck_oe_out ? sck_out : peer_sck;
	int    err_total  = 0;
	int    checks     = 0;
	int    cyc        = 0;

	always #10 clk_sys_in = ~clk_sys_in;

	synchronous_serial_shifter dut_u (.clk_sys_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out, .irq_out, .sck_in, .sck_out, .sck_oe_out, .sdi_in, .sdo_out);
	serial_peer_model peer_u (.clk_sys_in, .sck_in, .sdo_in(sdo_out), .sck_out(peer_sck), .sdi_out(sdi_in));

	task automatic wr(input addr_t a, input byte_t d);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	task automatic rd(input addr_t a);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 v = rdata_out;
		@(posedge clk_sys_in);
	endtask

	task automatic xfer(input byte_t c, input byte_t d, input byte_t p, input logic ei);
		wr(`SIO_CTRL_ADDR, c | 8'h04);
		peer_u.load(p, c[4], c[5]);
		wr(`SIO_BUF_ADDR, d);
		wr(`SIO_CTRL_ADDR, c | 8'h0c);
		if (c[7])
			peer_u.ext_run();
		for (int n = 0; n < 300 && !irq_out; n++)
			@(negedge clk_sys_in);
		@(posedge clk_sys_in);
		`CHK(irq_out, ei)
		`CHK(sck_oe_out, ~c[7])
		rd(`SIO_STAT_ADDR);
		`CHK(v, 8'h01)
		rd(`SIO_CTRL_ADDR);
		`CHK(v, c | 8'h05)
		rd(`SIO_BUF_ADDR);
		`CHK(v, p)
		if (c[6])
			`CHK(peer_u.rx, d)
		wr(`SIO_CTRL_ADDR, c | 8'h04);
		`CHK(irq_out, 1'b0)
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 4000) begin
			err_total++;
			conclude();
		end
	end

	initial begin
		repeat (6) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		@(posedge clk_sys_in);
		rd(`SIO_CTRL_ADDR);
		`CHK(v, `SIO_CTRL_RESET)
		rd(`SIO_BAUD_ADDR);
		`CHK(v, 8'h00)
		rd(8'hf0);
		`CHK(v, 8'h00)
		wr(`SIO_MASK_ADDR, 8'h01);
		xfer(8'h42, 8'ha5, 8'h3c, 1'b1);
		wr(`SIO_BAUD_ADDR, 8'h02);
		rd(`SIO_BAUD_ADDR);
		`CHK(v, 8'h02)
		xfer(8'h72, 8'h96, 8'hc3, 1'b1);
		xfer(8'h00, 8'hff, 8'h5a, 1'b0);
		wr(`SIO_MASK_ADDR, 8'h00);
		xfer(8'h42, 8'h0f, 8'hf0, 1'b0);
		wr(`SIO_MASK_ADDR, 8'h01);
		xfer(8'hc2, 8'h81, 8'h7e, 1'b1);
		wr(`SIO_CTRL_ADDR, 8'h4e);
		repeat (20) @(posedge clk_sys_in);
		wr(`SIO_BUF_ADDR, 8'h11);
		wr(`SIO_CTRL_ADDR, 8'h42);
		repeat (120) @(posedge clk_sys_in);
		`CHK(irq_out, 1'b0)
		`CHK(sck_out, 1'b0)
		rd(`SIO_STAT_ADDR);
		`CHK(v, 8'h02)
		rd(`SIO_CTRL_ADDR);
		`CHK(v, 8'h42)
		conclude();
	end
endmodule
